// file: logic/hbg_gate_ctrl.sv
// gate command merge, lockout, enable watchdog, sleep, fault latching, apb registers
// assumes pins and analogue monitor outputs arrive asynchronously to pclk
`timescale 1ns/1ps
`default_nettype none

module hbg_gate_ctrl
  import hbg_pkg::*;
#(
  parameter int unsigned ETO_CYCLES = ETO_CYC,
  parameter int unsigned WAKE_CYCLES = WAKE_CYC,
  parameter int unsigned SLEEP_CYCLES = SLEEP_CYC,
  parameter int unsigned RST_CYCLES = RST_PULSE_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // direct phase pins
  input wire logic phase_a_high_in,
  input wire logic phase_a_low_in_n,
  input wire logic phase_b_high_in_n,
  input wire logic phase_b_low_in,
  input wire logic enable_in,
  input wire logic sleep_reset_n,
  // analogue monitor outputs
  input wire logic logic_pin_overvolt,
  input wire logic overtemp_in,
  input wire logic serial_error_in,
  input wire logic [MON_W-1:0] monitor_in,
  input wire logic [DIAG_W-1:0] bridge_fault_in,
  // serial status shift-out
  input wire logic serial_strobe_n,
  input wire logic serial_clk,
  output logic serial_data_out,
  // gate commands and amp settings
  output hbg_gate_t gate_out,
  output logic sleep_out,
  output logic [7:0] amp_gain_value,
  output logic [11:0] amp_offset_mv
);

  localparam int SYNC_W = 10 + MON_W + DIAG_W;
  localparam int CW = 17;

  // counters are CW bits wide, so larger counts cannot be served
  if (ETO_CYCLES < 2 || ETO_CYCLES >= (1 << CW)) begin
    $error("hbg: bad ETO_CYCLES");
  end
  if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << CW)) begin
    $error("hbg: bad WAKE_CYCLES");
  end
  if (RST_CYCLES < 1 || RST_CYCLES >= SLEEP_CYCLES) begin
    $error("hbg: bad RST_CYCLES");
  end
  if (SLEEP_CYCLES < 2 || SLEEP_CYCLES >= (1 << CW)) begin
    $error("hbg: bad SLEEP_CYCLES");
  end

  function automatic logic [7:0] gain_of(input logic [2:0] code);
    logic [7:0] g;
    g = 8'h0A + 8'(code) * 8'h05;
    if (code == 3'h7) g = 8'h32;
    return g;
  endfunction

  function automatic logic [11:0] offset_of(input logic [3:0] code);
    logic [11:0] v;
    unique case (code)
      4'h0, 4'h1: v = 12'h000;
      4'h2, 4'h3: v = 12'h064;
      4'h4: v = 12'h0C8;
      4'h5: v = 12'h12C;
      4'h6: v = 12'h190;
      4'h7: v = 12'h1F4;
      4'h8: v = 12'h2EE;
      default: v = 12'h3E8 + 12'(code - 4'h9) * 12'h0FA;
    endcase
    return v;
  endfunction

  // two-flop synchroniser on every pin
  // resets to idle pin levels: no false strobe fall or sleep count after reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {4'h6, 1'b0, 1'b1, 3'h0, 1'b1,
    {(MON_W + DIAG_W){1'b0}}};
  logic [SYNC_W-1:0] sync1_q, sync2_q;
  wire logic [SYNC_W-1:0] pins = {phase_a_high_in, phase_a_low_in_n, phase_b_high_in_n,
    phase_b_low_in, enable_in, sleep_reset_n, logic_pin_overvolt, overtemp_in,
    serial_error_in, serial_strobe_n, monitor_in, bridge_fault_in};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end
  // shift clock kept separate so its own edge detector sees only stage two
  logic sck1_q, sck2_q, sck3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck1_q <= 1'b0;
      sck2_q <= 1'b0;
      sck3_q <= 1'b0;
    end else begin
      sck1_q <= serial_clk;
      sck2_q <= sck1_q;
      sck3_q <= sck2_q;
    end
  end

  wire logic [DIAG_W-1:0] s_diag = sync2_q[DIAG_W-1:0];
  wire logic [MON_W-1:0] s_mon = sync2_q[DIAG_W +: MON_W];
  wire logic s_strobe_n = sync2_q[DIAG_W + MON_W];
  wire logic s_se = sync2_q[DIAG_W + MON_W + 1];
  wire logic s_ot = sync2_q[DIAG_W + MON_W + 2];
  wire logic s_vlo = sync2_q[DIAG_W + MON_W + 3];
  wire logic s_rst_n = sync2_q[DIAG_W + MON_W + 4];
  wire logic s_en = sync2_q[DIAG_W + MON_W + 5];
  wire hbg_gate_t s_pin = '{a_hi: sync2_q[SYNC_W-1], a_lo: ~sync2_q[SYNC_W-2],
    b_hi: ~sync2_q[SYNC_W-3], b_lo: sync2_q[SYNC_W-4]};

  // registers
  logic [11:0] ctrl_q;
  logic [MASK_W-1:0] mask_q;
  hbg_fault_t bits_q, bits_d;
  logic por_q, bridge_lat_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;

  // apb decode
  wire logic setup = psel && !penable;
  wire logic acc_wr = psel && penable && pready_q && pwrite;
  wire logic hit_ctrl = paddr == CTRL_OFS;
  wire logic hit_mask = paddr == MASK_OFS;
  wire logic hit_stat = paddr == STATUS_OFS;
  wire logic hit_diag = paddr == DIAG_OFS;
  wire logic hit_frst = paddr == FRESET_OFS;
  wire logic hit_amp = paddr == AMP_OFS;
  wire logic mapped = hit_ctrl | hit_mask | hit_stat | hit_diag | hit_frst | hit_amp;
  wire logic fault_reset = acc_wr && hit_frst;

  wire hbg_gate_t c_req = ctrl_q[CTRL_GATE_LSB +: 4];
  wire logic wd_on = ctrl_q[CTRL_WD_BIT];
  wire logic [2:0] gain_code = ctrl_q[CTRL_GAIN_LSB +: 3];
  wire logic [3:0] ofs_code = ctrl_q[CTRL_OFS_LSB +: 4];

  // status image
  wire logic any_fault = por_q | bits_q.se | bits_q.ot | (|bits_q.mon) | (|bits_q.diag);
  wire logic [15:0] status = {any_fault, por_q, bits_q.se, bits_q.ot,
    bits_q.mon, |bits_q.diag, 4'h0};

  // sleep and reset pulse timing
  logic [CW-1:0] low_cnt_q, wake_cnt_q;
  // wake counter holds the gates off while the charge pump settles
  logic sleep_q, wake_q;
  wire logic low_end = s_rst_n && low_cnt_q != '0;
  wire logic wake_now = low_end && sleep_q;
  wire logic pulse_clr = low_end && !sleep_q && low_cnt_q >= CW'(RST_CYCLES);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_q <= '0;
      sleep_q <= 1'b0;
      wake_q <= 1'b0;
      wake_cnt_q <= '0;
    end else begin
      low_cnt_q <= s_rst_n ? '0 : (low_cnt_q == CW'(SLEEP_CYCLES) ? low_cnt_q : low_cnt_q + 1'b1);
      if (!s_rst_n && low_cnt_q == CW'(SLEEP_CYCLES)) sleep_q <= 1'b1;
      else if (s_rst_n) sleep_q <= 1'b0;
      if (wake_now) begin
        wake_q <= 1'b1;
        wake_cnt_q <= CW'(WAKE_CYCLES);
      end else if (wake_q) begin
        wake_cnt_q <= wake_cnt_q - 1'b1;
        if (wake_cnt_q == CW'(1)) wake_q <= 1'b0;
      end
    end
  end

  // enable watchdog
  logic en_prev_q, wd_act_q, eto_ev_q;
  logic [CW-1:0] wd_cnt_q;
  // in watchdog mode the outputs stay off until the next enable change
  wire logic en_edge = s_en != en_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_prev_q <= 1'b0;
      wd_act_q <= 1'b0;
      wd_cnt_q <= '0;
      eto_ev_q <= 1'b0;
    end else begin
      en_prev_q <= s_en;
      eto_ev_q <= 1'b0;
      if (!wd_on) begin
        wd_act_q <= 1'b0;
        wd_cnt_q <= '0;
      end else if (en_edge) begin
        wd_act_q <= 1'b1;
        wd_cnt_q <= CW'(ETO_CYCLES);
      end else if (wd_act_q) begin
        wd_cnt_q <= wd_cnt_q - 1'b1;
        if (wd_cnt_q == CW'(1)) begin
          wd_act_q <= 1'b0;
          eto_ev_q <= 1'b1;
        end
      end
    end
  end

  // fault bits: set wins over clear; masked monitors never set
  wire logic [MON_W-1:0] mon_ev = {s_mon[MON_W-1:MON_ETO+1], s_mon[MON_ETO] | eto_ev_q,
    s_mon[MON_VLO] | s_vlo, s_mon[MON_VLO-1:0]};
  wire logic [MON_W-1:0] mon_set = mon_ev & ~mask_q[DIAG_W +: MON_W];
  wire logic [DIAG_W-1:0] diag_set = s_diag & ~mask_q[DIAG_W-1:0];
  // limitation: a masked bridge fault neither sets its bit nor latches outputs off
  wire logic clr_bits = fault_reset || wake_now;
  always_comb begin
    bits_d = clr_bits ? '0 : bits_q;
    bits_d.ot = bits_d.ot | s_ot;
    bits_d.se = bits_d.se | s_se;
    bits_d.mon = bits_d.mon | mon_set;
    bits_d.diag = bits_d.diag | diag_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bits_q <= '0;
      por_q <= 1'b1;
      bridge_lat_q <= 1'b0;
    end else begin
      bits_q <= bits_d;
      if (clr_bits) por_q <= 1'b0;
      // latched output-off state from bridge faults, separate from the bits
      if (|diag_set) bridge_lat_q <= 1'b1;
      else if (pulse_clr || wake_now) bridge_lat_q <= 1'b0;
    end
  end

  // gate path: merge, lockout, then enable last
  wire hbg_gate_t req = s_pin | c_req;
  wire logic a_ok = !(req.a_hi && req.a_lo);
  wire logic b_ok = !(req.b_hi && req.b_lo);
  // lockout is purely combinational, so no per-phase timing state exists
  wire hbg_gate_t locked = '{a_hi: req.a_hi & a_ok, a_lo: req.a_lo & a_ok,
    b_hi: req.b_hi & b_ok, b_lo: req.b_lo & b_ok};
  wire logic run_ok = !sleep_q && !wake_q && !bridge_lat_q;
  wire logic en_gate = s_en && (!wd_on || wd_act_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_out <= '0;
      sleep_out <= 1'b0;
    end else begin
      gate_out <= (en_gate && run_ok) ? locked : '0;
      sleep_out <= sleep_q;
    end
  end

  // serial status shift-out
  logic [15:0] shift_q;
  logic strobe_prev_q;
  wire logic strobe_fall = strobe_prev_q && !s_strobe_n;
  wire logic sck_rise = sck2_q && !sck3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= '0;
      strobe_prev_q <= 1'b1;
      serial_data_out <= 1'b0;
    end else begin
      strobe_prev_q <= s_strobe_n;
      if (strobe_fall || acc_wr) shift_q <= status;
      else if (!s_strobe_n && sck_rise) shift_q <= {shift_q[14:0], 1'b0};
      serial_data_out <= strobe_fall ? status[ST_FF] : shift_q[15];
    end
  end

  // apb slave: no wait state; read data is registered in the setup phase so it comes from a flop
  // writes to read-only registers are ignored without an error
  wire logic [31:0] rd_mux = hit_ctrl ? {20'h0, ctrl_q} :
    hit_mask ? {{(32 - MASK_W){1'b0}}, mask_q} :
    hit_stat ? {16'h0, status} :
    hit_diag ? {{(32 - DIAG_W){1'b0}}, bits_q.diag} :
    hit_amp ? {4'h0, amp_offset_mv, 8'h0, amp_gain_value} : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      mask_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      amp_gain_value <= 8'h0A;
      amp_offset_mv <= 12'h000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      if (setup) prdata_q <= pwrite ? 32'h0 : rd_mux;
      if (wake_now) ctrl_q <= CTRL_RESET;
      else if (acc_wr && hit_ctrl) ctrl_q <= pwdata[11:0];
      if (acc_wr && hit_mask) mask_q <= pwdata[MASK_W-1:0];
      amp_gain_value <= gain_of(gain_code);
      amp_offset_mv <= offset_of(ofs_code);
    end
  end
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

endmodule

`default_nettype wire

// file: shared/hbg_pkg.sv
// constants, field layouts and carriers for the bridge gate control block
// assumes a 20 MHz pclk and a 32-bit apb register bus
package hbg_pkg;

  // clock and times
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SLEEP_US = 200;
  localparam int unsigned SLEEP_CYC = (SLEEP_US * (CLK_HZ / 1_000_000));
  localparam int unsigned FULL_SLEEP_US = 1000;
  localparam int unsigned WAKE_MS = 3;
  localparam int unsigned WAKE_CYC = WAKE_MS * (CLK_HZ / 1000);
  localparam int unsigned ETO_US = 1000;
  localparam int unsigned ETO_CYC = ETO_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RST_PULSE_CYC = 20;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MASK_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] DIAG_OFS = 8'h0C;
  localparam logic [7:0] FRESET_OFS = 8'h10;
  localparam logic [7:0] AMP_OFS = 8'h14;

  // control register fields
  localparam int CTRL_GATE_LSB = 0;
  localparam int CTRL_WD_BIT = 4;
  localparam int CTRL_GAIN_LSB = 5;
  localparam int CTRL_OFS_LSB = 8;
  localparam logic [11:0] CTRL_RESET = 12'h000;

  // status register bits
  localparam int ST_FF = 15;
  localparam int ST_POR = 14;
  localparam int ST_SE = 13;
  localparam int ST_OT = 12;
  localparam int ST_MON_LSB = 5;
  localparam int ST_BRIDGE = 4;
  localparam int MON_W = 7;
  // monitor slots: 0 tw 1 vso 2 vsu 3 vlo 4 eto 5 vro 6 vru
  localparam int MON_VLO = 3;
  localparam int MON_ETO = 4;
  localparam int DIAG_W = 13;
  localparam int MASK_W = MON_W + DIAG_W;

  // amp readback fields
  localparam int AMP_OFS_LSB = 16;

  typedef struct packed {
    logic a_hi;
    logic a_lo;
    logic b_hi;
    logic b_lo;
  } hbg_gate_t;

  typedef struct packed {
    logic ot;
    logic se;
    logic [MON_W-1:0] mon;
    logic [DIAG_W-1:0] diag;
  } hbg_fault_t;

endpackage

// file: test/hbg_gate_ctrl_checker.sv
// assertions on the bridge gate control ports
// assumes binding into hbg_gate_ctrl, one pclk domain
`timescale 1ns/1ps
`default_nettype none
module hbg_gate_ctrl_checker
  import hbg_pkg::*;
#(
  parameter int unsigned SLEEP_CYCLES = SLEEP_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // pins and outputs
  input wire logic enable_in,
  input wire logic sleep_reset_n,
  input wire hbg_gate_t gate_out,
  input wire logic sleep_out,
  input wire logic [7:0] amp_gain_value,
  input wire logic [11:0] amp_offset_mv
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire ctrl_wr = psel && penable && pready && pwrite && (paddr == CTRL_OFS);
  wire stat_rd = psel && penable && pready && !pwrite && (paddr == STATUS_OFS);
  wire logic [2:0] wr_gain = pwdata[7:5];
  wire logic [3:0] wr_ofs = pwdata[11:8];

  function automatic logic [7:0] gain_of(input logic [2:0] c);
    return (c == 3'h7) ? 8'h32 : 8'h0A + 8'h05 * {5'h0, c};
  endfunction
  function automatic logic [11:0] offset_of(input logic [3:0] c);
    if (c < 4'h2) return 12'h000;
    if (c < 4'h4) return 12'h064;
    if (c < 4'h8) return 12'h064 * {8'h0, c - 4'h2};
    if (c == 4'h8) return 12'h2EE;
    return 12'h3E8 + 12'h0FA * {8'h0, c - 4'h9};
  endfunction

  // long low spans need a counter, repetition would not unroll
  int unsigned low_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) low_q <= '0;
    else if (sleep_reset_n) low_q <= '0;
    else if (low_q < SLEEP_CYCLES + 8) low_q <= low_q + 1;

  property p_lock_a;
    !(gate_out.a_hi && gate_out.a_lo);
  endproperty
  a_lock_a: assert property (p_lock_a) else $error("phase a drives both on");
  property p_lock_b;
    !(gate_out.b_hi && gate_out.b_lo);
  endproperty
  a_lock_b: assert property (p_lock_b) else $error("phase b drives both on");
  property p_en_off;
    !enable_in [*3] |=> gate_out == '0;
  endproperty
  a_en_off: assert property (p_en_off) else $error("gate on with enable low");
  property p_sleep_entry;
    low_q == SLEEP_CYCLES + 6 |-> sleep_out;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep after long low");
  property p_sleep_off;
    sleep_out && $past(sleep_out) |-> gate_out == '0;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("gate on while asleep");
  property p_wake_hold;
    $fell(sleep_out) |-> (gate_out == '0) [*8];
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("gate on early after wake");
  property p_summary;
    stat_rd |-> prdata[15] == |prdata[14:4];
  endproperty
  a_summary: assert property (p_summary) else $error("summary flag disagrees");
  property p_gain;
    ctrl_wr |-> ##2 amp_gain_value == gain_of($past(wr_gain, 2));
  endproperty
  a_gain: assert property (p_gain) else $error("gain decode wrong");
  property p_offset;
    ctrl_wr |-> ##2 amp_offset_mv == offset_of($past(wr_ofs, 2));
  endproperty
  a_offset: assert property (p_offset) else $error("offset decode wrong");
endmodule

bind hbg_gate_ctrl hbg_gate_ctrl_checker #(.SLEEP_CYCLES(SLEEP_CYCLES)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .enable_in(enable_in), .sleep_reset_n(sleep_reset_n), .gate_out(gate_out),
  .sleep_out(sleep_out), .amp_gain_value(amp_gain_value), .amp_offset_mv(amp_offset_mv)
);
`default_nettype wire

// file: test/hbg_mcu_model.sv
// microcontroller side: phase pins, enable, sleep-reset, status strobe
// assumes calls start just after a pclk edge
`timescale 1ns/1ps
`default_nettype none
module hbg_mcu_model (
  // clock
  input wire logic pclk,
  // pins toward the block
  output logic [3:0] pins,
  output logic enable_in,
  output logic sleep_reset_n,
  output logic serial_strobe_n,
  output logic serial_clk
);
  initial begin
    pins = 4'h6; // idle: active-low pins held high
    enable_in = 1'b0;
    sleep_reset_n = 1'b1;
    serial_strobe_n = 1'b1;
    serial_clk = 1'b0; // shift clock stands still outside frames
  end
  task automatic set_pins(input logic [3:0] act);
    @(posedge pclk) pins <= 4'h6 ^ act;
  endtask
  task automatic set_en(input logic lvl);
    @(posedge pclk) enable_in <= lvl; // each call a change well inside the timeout
  endtask
  task automatic hold_reset(input int n);
    @(posedge pclk) sleep_reset_n <= 1'b0;
    repeat (n) @(posedge pclk);
    sleep_reset_n <= 1'b1; // short pulse releases the bridge-fault output latch, long one sleeps
  endtask
  task automatic strobe(input logic lvl);
    @(posedge pclk) serial_strobe_n <= lvl;
  endtask
endmodule
`default_nettype wire

// file: test/hbridge_gate_control_diag_test.sv
// self-checking bench for the bridge gate control block
// assumes 20 MHz pclk, shortened counts, microcontroller model on the pins
`timescale 1ns/1ps
`default_nettype none
module hbridge_gate_control_diag_test;
  import hbg_pkg::*;
  // short counts keep the run brief
  localparam int ENABLE_TIMEOUT_FLAG = 16, WAKE = 20, SLP = 64, RST = 4;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, ovl, ot, se;
  logic [7:0] paddr, gain_v;
  logic [11:0] ofs_v;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, sdo, sleep_out, en, slp_n, str_n, sck;
  logic [MON_W-1:0] mon;
  logic [DIAG_W-1:0] brf;
  logic [3:0] pins;
  hbg_gate_t gate_out;
  int failures = 0, n_tests = 0;
  logic [3:0] px [9] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hC, 4'h3, 4'h0, 4'h4, 4'h1};
  logic [3:0] cx [9] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h8, 4'h1};
  logic [3:0] gx [9] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'h0, 4'h8, 4'h0, 4'h1};
  logic [7:0] gains [8] = '{8'h0A, 8'h0F, 8'h14, 8'h19, 8'h1E, 8'h23, 8'h28, 8'h32};
  logic [11:0] ofs [16] = '{12'h000, 12'h000, 12'h064, 12'h064, 12'h0C8, 12'h12C, 12'h190,
    12'h1F4, 12'h2EE, 12'h3E8, 12'h4E2, 12'h5DC, 12'h6D6, 12'h7D0, 12'h8CA, 12'h9C4};

  hbg_mcu_model i_mcu (.pclk(pclk), .pins(pins), .enable_in(en), .sleep_reset_n(slp_n),
    .serial_strobe_n(str_n), .serial_clk(sck));
  hbg_gate_ctrl #(.ETO_CYCLES(ENABLE_TIMEOUT_FLAG), .WAKE_CYCLES(WAKE), .SLEEP_CYCLES(SLP),
    .RST_CYCLES(RST)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_a_high_in(pins[3]), .phase_a_low_in_n(pins[2]), .phase_b_high_in_n(pins[1]),
    .phase_b_low_in(pins[0]), .enable_in(en), .sleep_reset_n(slp_n),
    .logic_pin_overvolt(ovl), .overtemp_in(ot), .serial_error_in(se), .monitor_in(mon),
    .bridge_fault_in(brf), .serial_strobe_n(str_n), .serial_clk(sck),
    .serial_data_out(sdo), .gate_out(gate_out), .sleep_out(sleep_out),
    .amp_gain_value(gain_v), .amp_offset_mv(ofs_v));

  always #25 pclk = ~pclk;

  task automatic results;
    $display("failures %0d, n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // starts just after an edge; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  task automatic gate(input logic [3:0] exp);
    cyc(5);
    check("gate", {28'h0, gate_out}, {28'h0, exp});
  endtask

  initial begin
    cyc(20000);
    failures++;
    results();
  end

  initial begin
    {presetn, psel, penable, pwrite, ovl, ot, se} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    mon = '0;
    brf = '0;
    cyc(2);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(STATUS_OFS, 32'h0000C000, "status after reset");
    rdchk(AMP_OFS, 32'h0000000A, "amp after reset");
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    apb(1'b1, FRESET_OFS, 32'h0);
    rdchk(STATUS_OFS, 32'h0, "status cleared");
    i_mcu.set_en(1'b1);
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, CTRL_OFS, {28'h0, cx[i]});
      i_mcu.set_pins(px[i]);
      gate(gx[i]);
    end
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, CTRL_OFS, {20'h0, 4'(i), 3'(i), 5'h0});
      rdchk(AMP_OFS, {4'h0, ofs[i], 8'h0, gains[i % 8]}, "amp");
      check("gain out", {24'h0, gain_v}, {24'h0, gains[i % 8]});
      check("offset out", {20'h0, ofs_v}, {20'h0, ofs[i]});
    end
    // watchdog armed while enable already high: no change seen yet
    i_mcu.set_pins(4'h8);
    apb(1'b1, CTRL_OFS, 32'h00000010);
    gate(4'h0);
    i_mcu.set_en(1'b0);
    i_mcu.set_en(1'b1);
    gate(4'h8);
    for (int i = 0; i < 4; i++) begin
      i_mcu.set_en(1'b0);
      i_mcu.set_en(1'b1);
      gate(4'h8);
    end
    cyc(ENABLE_TIMEOUT_FLAG + 8);
    gate(4'h0);
    rdchk(STATUS_OFS, 32'h00008200, "timeout flag");
    i_mcu.set_en(1'b0);
    i_mcu.set_en(1'b1);
    gate(4'h8);
    rdchk(STATUS_OFS, 32'h00008200, "timeout flag kept");
    apb(1'b1, CTRL_OFS, 32'h0);
    i_mcu.set_en(1'b0);
    gate(4'h0);
    i_mcu.set_en(1'b1);
    apb(1'b1, FRESET_OFS, 32'h0);
    brf <= 13'h0001;
    cyc(3);
    brf <= '0;
    gate(4'h0);
    rdchk(DIAG_OFS, 32'h00000001, "diag latched");
    i_mcu.hold_reset(RST + 2);
    gate(4'h8);
    rdchk(DIAG_OFS, 32'h00000001, "diag kept");
    rdchk(STATUS_OFS, 32'h00008010, "status bridge");
    i_mcu.strobe(1'b0);
    cyc(6);
    check("poll bit", {31'h0, sdo}, 32'h1);
    i_mcu.strobe(1'b1);
    apb(1'b1, FRESET_OFS, 32'h0);
    i_mcu.strobe(1'b0);
    cyc(6);
    check("poll bit clear", {31'h0, sdo}, 32'h0);
    i_mcu.strobe(1'b1);
    apb(1'b1, MASK_OFS, 32'h000FFFFF);
    {ovl, ot, se} <= 3'h7;
    mon <= '1;
    cyc(3);
    {ovl, ot, se} <= 3'h0;
    mon <= '0;
    cyc(4);
    rdchk(STATUS_OFS, 32'h0000B000, "masked status");
    apb(1'b1, MASK_OFS, 32'h0);
    ovl <= 1'b1;
    mon <= 7'h01;
    cyc(3);
    ovl <= 1'b0;
    mon <= '0;
    cyc(4);
    rdchk(STATUS_OFS, 32'h0000B120, "overvolt status");
    i_mcu.hold_reset(SLP + 8);
    check("asleep", {31'h0, sleep_out}, 32'h1);
    gate(4'h0);
    cyc(WAKE + 8);
    gate(4'h8);
    rdchk(STATUS_OFS, 32'h0, "status after wake");
    results();
  end
endmodule
`default_nettype wire
